// >>> gcrf_consts.vh
// Constants for the tape block framer
`ifndef GCRF_CONSTS_VH
`define GCRF_CONSTS_VH

// ----------------------------------------------------------------
// Character layout: bits 0..7 are channels 0..7, bit 8 is parity
// ----------------------------------------------------------------
`define GCRF_CHAR_W        9
`define GCRF_CH_P          8

// ----------------------------------------------------------------
// Subgroup length, sync run length in subgroups, and subgroup patterns, first character in the top bit
// ----------------------------------------------------------------
`define GCRF_SG_CHARS      16'h0005
`define GCRF_SYNC_SGS      16'h000e
`define GCRF_PAT_LEAD_TERM 5'h15
`define GCRF_PAT_PRE_SEC   5'h0f
`define GCRF_PAT_ALL_ONES  5'h1f
`define GCRF_PAT_START_MRK 5'h07
`define GCRF_PAT_END_MRK   5'h1c
`define GCRF_PAT_POST_SEC  5'h1e
`define GCRF_PAT_TRAIL_TRM 5'h15

// ----------------------------------------------------------------
// Erasure masks, one bit per channel
// ----------------------------------------------------------------
`define GCRF_ERASE_ID      9'h092
`define GCRF_ERASE_TMARK   9'h01a

// ----------------------------------------------------------------
// Default run lengths in characters
// ----------------------------------------------------------------
`define GCRF_ARA_ID_CHARS  16'h0040
`define GCRF_ARA_CHARS     16'h0040
`define GCRF_TMARK_CHARS   16'h0040

`endif

// >>> gcrf_lrc.v
// Per-channel longitudinal check accumulator
`timescale 1ns/10ps
`default_nettype none

module gcrf_lrc #(
    parameter W = 9
) (
    input  wire         core_clk_in,
    input  wire         resetn_in,
    input  wire         clear_in,
    input  wire         acc_in,
    input  wire [W-1:0] char_in,
    output wire [W-1:0] lrc_out
);
    reg [W-1:0] lrc_q;

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_ch
            always @(posedge core_clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    lrc_q[i] <= 1'b0;
                end else if (clear_in) begin
                    lrc_q[i] <= 1'b0;
                end else if (acc_in) begin
                    lrc_q[i] <= lrc_q[i] ^ char_in[i];
                end
            end
        end
    endgenerate

    assign lrc_out = lrc_q;
endmodule // gcrf_lrc

`default_nettype wire

// >>> gcrf_framer.v
// Tape block framer: bursts, preamble, data, end marker, postamble, tape mark
`timescale 1ns/10ps
`default_nettype none
`include "gcrf_consts.vh"

module gcrf_framer #(
    parameter [15:0] ARA_ID_CHARS = `GCRF_ARA_ID_CHARS,
    parameter [15:0] ARA_CHARS    = `GCRF_ARA_CHARS,
    parameter [15:0] TMARK_CHARS  = `GCRF_TMARK_CHARS
) (
    input  wire       core_clk_in,
    input  wire       resetn_in,
    input  wire       bot_in,
    input  wire       cmd_block_in,
    input  wire       cmd_tape_mark_in,
    input  wire       data_valid_in,
    input  wire [8:0] data_in,
    input  wire       data_end_in,
    input  wire       data_last_in,
    output wire       data_ready_out,
    input  wire       char_ready_in,
    output reg        char_valid_out,
    output reg  [8:0] char_out,
    output reg  [8:0] erase_mask_out,
    output wire       busy_out
);
    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam [3:0] S_IDLE      = 4'h0;
    localparam [3:0] S_ARA_ID    = 4'h1;
    localparam [3:0] S_ARA       = 4'h2;
    localparam [3:0] S_PRE_TERM  = 4'h3;
    localparam [3:0] S_PRE_SEC   = 4'h4;
    localparam [3:0] S_PRE_SYNC  = 4'h5;
    localparam [3:0] S_PRE_MARK  = 4'h6;
    localparam [3:0] S_DATA      = 4'h7;
    localparam [3:0] S_END_MARK  = 4'h8;
    localparam [3:0] S_TRAILER   = 4'h9;
    localparam [3:0] S_POST_MARK = 4'ha;
    localparam [3:0] S_POST_SYNC = 4'hb;
    localparam [3:0] S_POST_SEC  = 4'hc;
    localparam [3:0] S_POST_TERM = 4'hd;
    localparam [3:0] S_TMARK     = 4'he;

    // Counter limits for subgroup and synchronisation runs
    localparam [15:0] SG_LEN   = `GCRF_SG_CHARS;
    localparam [15:0] SYNC_LEN = `GCRF_SG_CHARS * `GCRF_SYNC_SGS;

    // ----------------------------------------------------------------
    // Tape-start sensor synchroniser
    // ----------------------------------------------------------------
    reg bot_meta_q;
    reg bot_q;
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bot_meta_q <= 1'b0;
            bot_q      <= 1'b0;
        end else begin
            bot_meta_q <= bot_in;
            bot_q      <= bot_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    reg  [3:0]  state_q;
    reg  [3:0]  state_d;
    reg  [15:0] cnt_q;
    reg  [15:0] cnt_d;
    reg  [15:0] limit;
    reg  [4:0]  pat;
    reg         pat_state;
    reg  [8:0]  char_d;
    reg  [8:0]  mask_d;
    reg         valid_d;
    reg         lrc_clear;
    reg         lrc_acc;
    wire [8:0]  lrc;
    wire        adv;
    wire        last;
    wire        pass;

    // Output register may load when empty or when the write channel takes it
    assign adv            = !char_valid_out || char_ready_in;
    assign last           = (cnt_q == limit - 16'h0001);
    assign pass           = (state_q == S_DATA) || (state_q == S_TRAILER);
    assign data_ready_out = adv && pass;
    assign busy_out       = (state_q != S_IDLE);

    always @* begin
        pat       = `GCRF_PAT_ALL_ONES;
        pat_state = 1'b1;
        limit     = SG_LEN;
        mask_d    = 9'h000;
        case (state_q)
            S_ARA_ID: begin
                limit  = ARA_ID_CHARS;
                mask_d = `GCRF_ERASE_ID;
            end
            S_ARA:       limit = ARA_CHARS;
            S_PRE_TERM:  pat = `GCRF_PAT_LEAD_TERM;
            S_PRE_SEC:   pat = `GCRF_PAT_PRE_SEC;
            S_PRE_SYNC:  limit = SYNC_LEN;
            S_PRE_MARK:  pat = `GCRF_PAT_START_MRK;
            S_END_MARK:  pat = `GCRF_PAT_ALL_ONES;
            S_POST_MARK: pat = `GCRF_PAT_END_MRK;
            S_POST_SYNC: limit = SYNC_LEN;
            S_POST_SEC:  pat = `GCRF_PAT_POST_SEC;
            S_POST_TERM: pat = `GCRF_PAT_TRAIL_TRM;
            S_TMARK: begin
                limit  = TMARK_CHARS;
                mask_d = `GCRF_ERASE_TMARK;
            end
            default:     pat_state = 1'b0;
        endcase
    end

    always @* begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        valid_d   = 1'b0;
        char_d    = char_out;
        lrc_clear = 1'b0;
        lrc_acc   = 1'b0;
        if (state_q == S_IDLE) begin
            cnt_d = 16'h0000;
            // Last character of a sequence may still wait for the channel
            valid_d = char_valid_out && !char_ready_in;
            if (cmd_block_in) begin
                lrc_clear = 1'b1;
                state_d   = bot_q ? S_ARA_ID : S_PRE_TERM;
            end else if (cmd_tape_mark_in) begin
                state_d = S_TMARK;
            end
        end else if (adv && pass) begin
            if (data_valid_in) begin
                valid_d = 1'b1;
                char_d  = data_in;
                lrc_acc = 1'b1;
                if (state_q == S_DATA && data_end_in) begin
                    state_d = S_END_MARK;
                end else if (state_q == S_TRAILER && data_last_in) begin
                    state_d = S_POST_MARK;
                end
            end
        end else if (adv && pat_state) begin
            valid_d = 1'b1;
            // Bursts and sync runs are solid ones; subgroups follow the pattern
            if (limit == SG_LEN) begin
                char_d = {9{pat[3'd4 - cnt_q[2:0]]}};
            end else begin
                char_d = 9'h1ff;
            end
            char_d = char_d & ~mask_d;
            // Check character replaces the last termination character
            if (state_q == S_POST_TERM && last) begin
                char_d = lrc;
            end else if (state_q >= S_PRE_TERM && state_q <= S_POST_TERM) begin
                lrc_acc = 1'b1;
            end
            cnt_d = cnt_q + 16'h0001;
            if (last) begin
                cnt_d = 16'h0000;
                case (state_q)
                    S_ARA_ID:    state_d = S_ARA;
                    S_ARA:       state_d = S_PRE_TERM;
                    S_PRE_TERM:  state_d = S_PRE_SEC;
                    S_PRE_SEC:   state_d = S_PRE_SYNC;
                    S_PRE_SYNC:  state_d = S_PRE_MARK;
                    S_PRE_MARK:  state_d = S_DATA;
                    S_END_MARK:  state_d = S_TRAILER;
                    S_POST_MARK: state_d = S_POST_SYNC;
                    S_POST_SYNC: state_d = S_POST_SEC;
                    S_POST_SEC:  state_d = S_POST_TERM;
                    default:     state_d = S_IDLE;
                endcase
            end
        end else if (!adv) begin
            // Stalled: hold the character and freeze the sequence
            valid_d = char_valid_out;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q        <= S_IDLE;
            cnt_q          <= 16'h0000;
            char_valid_out <= 1'b0;
            char_out       <= 9'h000;
            erase_mask_out <= 9'h000;
        end else begin
            state_q        <= state_d;
            cnt_q          <= cnt_d;
            char_valid_out <= valid_d;
            if (adv && valid_d) begin
                char_out       <= char_d;
                erase_mask_out <= pass ? 9'h000 : mask_d;
            end
        end
    end

    // ----------------------------------------------------------------
    // Check accumulator
    // ----------------------------------------------------------------
    // Sees the characters loaded from the leading termination through the postamble, except the check character
    gcrf_lrc #(
        .W (`GCRF_CHAR_W)
    ) u_lrc (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .clear_in    (lrc_clear),
        .acc_in      (lrc_acc),
        .char_in     (char_d),
        .lrc_out     (lrc)
    );
endmodule // gcrf_framer

`default_nettype wire

// >>> gcrf_framer_properties.sv
// Port checker for the tape block framer
`timescale 1ns/10ps
`default_nettype none
module gcrf_framer_checker (
    input wire logic       core_clk_in,
    input wire logic       resetn_in,
    input wire logic       cmd_block_in,
    input wire logic       cmd_tape_mark_in,
    input wire logic       data_valid_in,
    input wire logic [8:0] data_in,
    input wire logic       data_end_in,
    input wire logic       data_ready_out,
    input wire logic       char_ready_in,
    input wire logic       char_valid_out,
    input wire logic [8:0] char_out,
    input wire logic [8:0] erase_mask_out,
    input wire logic       busy_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    a_cmd_starts_busy: assert property (!busy_out && (cmd_block_in || cmd_tape_mark_in) |=> busy_out)
        else $error("command not started");
    a_first_char_due: assert property ($rose(busy_out) |=> char_valid_out)
        else $error("first character late");
    a_stall_holds_char: assert property (char_valid_out && !char_ready_in |=>
        char_valid_out && $stable(char_out) && $stable(erase_mask_out))
        else $error("character changed while stalled");
    a_erased_bits_zero: assert property (char_valid_out |-> (char_out & erase_mask_out) == 9'h000)
        else $error("erased channel carries a one");
    a_erase_mask_legal: assert property (char_valid_out |->
        erase_mask_out inside {9'h000, 9'h092, 9'h01a})
        else $error("illegal erase mask");
    a_ready_needs_busy: assert property (data_ready_out |-> busy_out)
        else $error("data ready while idle");
    a_data_passes: assert property (data_valid_in && data_ready_out |=>
        char_valid_out && char_out == $past(data_in))
        else $error("data character not passed");
    a_end_marker_gap: assert property (data_valid_in && data_ready_out && data_end_in |=>
        !data_ready_out [*5])
        else $error("end marker not inserted");
    cover property (char_valid_out && erase_mask_out == 9'h092);
    cover property (char_valid_out && erase_mask_out == 9'h01a);
    cover property (data_valid_in && data_ready_out && data_end_in);
endmodule // gcrf_framer_checker
`default_nettype wire

// >>> gcrf_chan_model.sv
// Write channel model: takes characters with random stalls
`timescale 1ns/10ps
`default_nettype none
module gcrf_chan_model (
    input  wire logic core_clk_in,
    input  wire logic resetn_in,
    output var logic  char_ready_out
);
    integer seed = 32'h3c096921;
    // Stalls a quarter of the cycles so back-pressure is exercised
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) char_ready_out <= 1'b0;
        else char_ready_out <= ($random(seed) & 3) != 0;
    end
endmodule // gcrf_chan_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the tape block framer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int N = 4;
    logic        core_clk_in, resetn_in, bot_in, cmd_block_in, cmd_tape_mark_in;
    logic        data_valid_in, data_end_in, data_last_in, acc;
    logic [8:0]  data_in, lrc;
    wire         char_ready_in, data_ready_out, char_valid_out, busy_out;
    wire  [8:0]  char_out, erase_mask_out;
    logic [17:0] exp_q[$];
    integer      seed = 32'h3c096921;
    integer      fail_count = 0;
    integer      samples_checked = 0;
    gcrf_framer #(.ARA_ID_CHARS(N), .ARA_CHARS(N), .TMARK_CHARS(N)) gcrf_framer_i (
        .core_clk_in(core_clk_in), .resetn_in(resetn_in), .bot_in(bot_in),
        .cmd_block_in(cmd_block_in), .cmd_tape_mark_in(cmd_tape_mark_in),
        .data_valid_in(data_valid_in), .data_in(data_in), .data_end_in(data_end_in),
        .data_last_in(data_last_in), .data_ready_out(data_ready_out),
        .char_ready_in(char_ready_in), .char_valid_out(char_valid_out),
        .char_out(char_out), .erase_mask_out(erase_mask_out), .busy_out(busy_out));
    gcrf_chan_model gcrf_chan_model_i (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
        .char_ready_out(char_ready_in));
    initial begin
        core_clk_in = 1'b0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic note(input logic [8:0] c, input logic [8:0] m);
        exp_q.push_back({m, c & ~m});
        if (acc) lrc = lrc ^ (c & ~m);
    endtask
    task automatic pat(input logic [4:0] p);
        for (int k = 4; k >= 0; k--) note({9{p[k]}}, 9'h000);
    endtask
    task automatic issue(input logic blk, input logic refuse);
        while (busy_out) @(negedge core_clk_in);
        @(posedge core_clk_in);
        cmd_block_in <= blk;
        cmd_tape_mark_in <= !blk;
        @(posedge core_clk_in);
        cmd_block_in <= 1'b0;
        cmd_tape_mark_in <= refuse;
        @(posedge core_clk_in);
        cmd_tape_mark_in <= 1'b0;
    endtask
    task automatic send(input logic [8:0] d, input logic e, input logic l);
        data_valid_in <= 1'b1;
        data_in <= d;
        data_end_in <= e;
        data_last_in <= l;
        do @(negedge core_clk_in); while (!data_ready_out);
        @(posedge core_clk_in);
    endtask
    task automatic wait_done(input string name);
        do @(negedge core_clk_in); while (exp_q.size() != 0 || busy_out);
        $display("%s finished, %0d checks so far", name, samples_checked);
    endtask
    task automatic run_block(input int nd, input int nt, input logic bot);
        logic [8:0] d[$];
        logic [8:0] v;
        bot_in <= bot;
        repeat (4) @(posedge core_clk_in);
        for (int i = 0; i < N && bot; i++) note(9'h1ff, 9'h092);
        for (int i = 0; i < N && bot; i++) note(9'h1ff, 9'h000);
        lrc = 9'h000;
        acc = 1'b1;
        pat(5'h15);
        pat(5'h0f);
        repeat (14) pat(5'h1f);
        pat(5'h07);
        for (int i = 0; i < nd + nt; i++) begin
            v = 9'($random(seed));
            d.push_back(v);
            note(v, 9'h000);
            if (i == nd - 1) pat(5'h1f);
        end
        pat(5'h1c);
        repeat (14) pat(5'h1f);
        pat(5'h1e);
        for (int k = 4; k > 0; k--) note({9{!k[0]}}, 9'h000);
        exp_q.push_back({9'h000, lrc});
        acc = 1'b0;
        // Tape mark request lands while busy and must be dropped
        issue(1'b1, 1'b1);
        foreach (d[i]) send(d[i], i == nd - 1, i == nd + nt - 1);
        data_valid_in <= 1'b0;
        wait_done("block");
    endtask
    always @(posedge core_clk_in) begin
        if (resetn_in && char_valid_out && char_ready_in) begin
            if (exp_q.size() == 0) check({erase_mask_out, char_out}, 18'hx);
            else check({erase_mask_out, char_out}, exp_q.pop_front());
        end
    end
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        {resetn_in, bot_in, cmd_block_in, cmd_tape_mark_in} = 4'h0;
        {data_valid_in, data_end_in, data_last_in, acc} = 4'h0;
        data_in = 9'h000;
        lrc = 9'h000;
        repeat (20) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        run_block(1, 1, 1'b0);
        run_block(3 + ($random(seed) & 7), 2, 1'b1);
        for (int i = 0; i < N; i++) note(9'h1ff, 9'h01a);
        issue(1'b0, 1'b0);
        wait_done("tape mark");
        run_block(4, 1, 1'b0);
        end_sim;
    end
    initial begin
        repeat (20000) @(posedge core_clk_in);
        fail_count++;
        end_sim;
    end
endmodule // tb_top
bind gcrf_framer gcrf_framer_checker gcrf_framer_checker_i (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .cmd_block_in(cmd_block_in),
    .cmd_tape_mark_in(cmd_tape_mark_in), .data_valid_in(data_valid_in), .data_in(data_in),
    .data_end_in(data_end_in), .data_ready_out(data_ready_out),
    .char_ready_in(char_ready_in), .char_valid_out(char_valid_out), .char_out(char_out),
    .erase_mask_out(erase_mask_out), .busy_out(busy_out));
`default_nettype wire
